// file: fsr_consts.svh
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH
`define FSR_TARGET_ADDR 7'h50
`define FSR_BYTES_PER_READ 3'h5
`define FSR_FLOW_BITS 12
`define FSR_FLOW_ZERO 12'h199
`define FSR_FLOW_FULL 12'hE66
`define FSR_FIFO_WIDTH 12
`define FSR_FIFO_DEPTH 8
`define FSR_BYTE_LAST_BIT 3'h7
`define FSR_SAMPLE_PERIOD_US 10
`define FSR_CLK_MHZ 100
`define FSR_SAMPLE_CYCLES (`FSR_SAMPLE_PERIOD_US * `FSR_CLK_MHZ)
`endif

// file: fsr_pkg.sv
package fsr_pkg;
  typedef logic [11:0] fsr_flow_t;
  typedef logic [7:0] fsr_byte_t;
  typedef enum logic [2:0] {
    FSR_IDLE = 3'b000,
    FSR_ADDR = 3'b001,
    FSR_AACK = 3'b010,
    FSR_SEND = 3'b011,
    FSR_MACK = 3'b100
  } fsr_state_t;
endpackage

// file: fsr_stream_if.sv
`timescale 1ns/100ps
interface fsr_stream_if;
  logic valid;
  logic ready;
  logic [11:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: fsr_fifo.sv
`timescale 1ns/100ps
module fsr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  fsr_stream_if.snk wr,
  fsr_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (wr.valid && !full) begin
      mem[wp_r[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
    end else if (wr.valid && !full) begin
      wp_r <= wp_r + 1'b1;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rp_r <= '0;
    end else if (rd.ready && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// file: fsr_sampler.sv
`timescale 1ns/100ps
`include "fsr_consts.svh"
module fsr_sampler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [11:0] raw_in,
  fsr_stream_if.src out
);
  import fsr_pkg::*;
  localparam int CW = $clog2(`FSR_SAMPLE_CYCLES);
  logic [CW-1:0] cnt_r;
  logic tick;
  fsr_flow_t clamp;
  assign tick = (cnt_r == CW'(`FSR_SAMPLE_CYCLES - 1));
  // Keep output inside the documented count range
  always_comb begin
    clamp = raw_in;
    if (raw_in < `FSR_FLOW_ZERO) begin
      clamp = `FSR_FLOW_ZERO;
    end else if (raw_in > `FSR_FLOW_FULL) begin
      clamp = `FSR_FLOW_FULL;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // Free-running sampling, no trigger needed; drops samples when full
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out.valid <= 1'b0;
      out.data <= `FSR_FLOW_ZERO;
    end else if (tick) begin
      out.valid <= 1'b1;
      out.data <= clamp;
    end else if (out.ready) begin
      out.valid <= 1'b0;
    end
  end
endmodule

// file: fsr_i2c_readout.sv
// Summary of operation
// - Target only I2C; oversampling handles 100 kHz and 400 kHz.
// - Answer only reads to 7-bit address 0x50.
// - SDA falling while SCL high starts a transaction.
// - SDA rising while SCL high stops and returns to idle.
// - Eight data bits then one response bit; low means acknowledge.
// - Receiver pulls SDA low for acknowledge then releases it.
// - Sample SDA at SCL rise; change SDA only while SCL low.
// - Measure continuously; reads need no trigger.
// - Send whole bytes, most significant bit first.
// - Checksum first, then flow high byte, then low byte.
// - Flow is 12 bits; upper nibble of high byte is zero.
// - Checksum is two's complement of data byte sum.
// - Five bytes: checksum and four data bytes, flow repeated.
// - Output counts run from 409 to 3686 over flow range.
`timescale 1ns/100ps
`include "fsr_consts.svh"
module fsr_i2c_readout (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire fsr_pkg::fsr_flow_t flow_raw_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic busy_out,
  output fsr_pkg::fsr_flow_t flow_out
);
  import fsr_pkg::*;
  fsr_stream_if smp ();
  fsr_stream_if fif ();

  fsr_sampler u_sampler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(flow_raw_in),
    .out(smp)
  );

  fsr_fifo #(
    .WIDTH(`FSR_FIFO_WIDTH),
    .DEPTH(`FSR_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr(smp),
    .rd(fif)
  );

  // Two-flop synchronisers; stage two and a third delay flop for edge detection are read
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  // Latest sample, kept fresh from the FIFO at all times
  fsr_flow_t latest_r;
  assign fif.ready = 1'b1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latest_r <= `FSR_FLOW_ZERO;
    end else if (fif.valid) begin
      latest_r <= fif.data;
    end
  end

  fsr_state_t st_r;
  logic [2:0] bit_r;
  logic [2:0] byte_r;
  logic [7:0] shin_r;
  logic [7:0] shout_r;
  fsr_flow_t snap_r;
  fsr_byte_t hi_b;
  fsr_byte_t lo_b;
  fsr_byte_t csum;
  fsr_byte_t next_b;
  logic got8_r;
  logic addr_hit;

  assign hi_b = {4'h0, snap_r[11:8]};
  assign lo_b = snap_r[7:0];
  // Needs a full fresh byte; a stale shift value from the last frame never matches
  assign addr_hit = got8_r && (shin_r == {`FSR_TARGET_ADDR, 1'b1});
  // Flow repeated in bytes four and five, all four summed
  assign csum = 8'h00 - (hi_b + lo_b + hi_b + lo_b);
  always_comb begin
    case (byte_r)
      3'h0: next_b = hi_b;
      3'h1: next_b = lo_b;
      3'h2: next_b = hi_b;
      3'h3: next_b = lo_b;
      default: next_b = 8'h00;
    endcase
  end

  // Byte phase machine; SDA driven only after SCL falls
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= FSR_IDLE;
      bit_r <= 3'h0;
      byte_r <= 3'h0;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      snap_r <= `FSR_FLOW_ZERO;
      got8_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= FSR_IDLE;
    end else if (start_det) begin
      st_r <= FSR_ADDR;
      bit_r <= 3'h0;
      shin_r <= 8'h00;
      got8_r <= 1'b0;
      snap_r <= latest_r;
    end else begin
      case (st_r)
        FSR_IDLE: begin
          bit_r <= 3'h0;
        end
        FSR_ADDR: begin
          if (scl_rise) begin
            shin_r <= {shin_r[6:0], sda_s2_r};
            bit_r <= bit_r + 3'h1;
            got8_r <= (bit_r == `FSR_BYTE_LAST_BIT);
          end
          if (scl_fall && addr_hit) begin
            st_r <= FSR_AACK;
          end else if (scl_fall && got8_r) begin
            st_r <= FSR_IDLE;
          end
        end
        FSR_AACK: begin
          if (scl_fall) begin
            st_r <= FSR_SEND;
            shout_r <= csum;
            byte_r <= 3'h0;
            bit_r <= 3'h0;
          end
        end
        FSR_SEND: begin
          if (scl_fall) begin
            if (bit_r == `FSR_BYTE_LAST_BIT) begin
              st_r <= FSR_MACK;
            end else begin
              shout_r <= {shout_r[6:0], 1'b0};
            end
            bit_r <= bit_r + 3'h1;
          end
        end
        FSR_MACK: begin
          if (scl_rise) begin
            // High response ends the read
            if (sda_s2_r) begin
              st_r <= FSR_IDLE;
            end else begin
              shout_r <= next_b;
              byte_r <= byte_r + 3'h1;
            end
          end
          if (scl_fall) begin
            st_r <= FSR_SEND;
          end
        end
        default: st_r <= FSR_IDLE;
      endcase
    end
  end

  // Open drain: enable low means pin driven low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else if (scl_fall || stop_det || start_det) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      if (!stop_det && !start_det) begin
        if (st_r == FSR_ADDR && addr_hit) begin
          sda_oe_n_out <= 1'b0;
        end else if (st_r == FSR_AACK) begin
          sda_oe_n_out <= csum[7];
        end else if (st_r == FSR_SEND && bit_r != `FSR_BYTE_LAST_BIT) begin
          sda_oe_n_out <= shout_r[6];
        end else if (st_r == FSR_MACK) begin
          sda_oe_n_out <= shout_r[7];
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      flow_out <= `FSR_FLOW_ZERO;
    end else begin
      busy_out <= (st_r != FSR_IDLE);
      flow_out <= latest_r;
    end
  end
endmodule

// file: fsr_i2c_ctl.sv
`timescale 1ns/100ps
module fsr_i2c_ctl (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // Clock rests high between frames
  initial {scl_out, sda_out} = 2'b11;
  task automatic bit_io(input logic b, output logic r);
    #60 sda_out = b;
    #20 scl_out = 1'b1;
    #40 r = sda_in;
    #40 scl_out = 1'b0;
  endtask
  task automatic start_c();
    #60 sda_out = 1'b1;
    #20 scl_out = 1'b1;
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  task automatic stop_c();
    #60 sda_out = 1'b0;
    #20 scl_out = 1'b1;
    #40 sda_out = 1'b1;
    #40;
  endtask
  // Writing all ones releases the line so the target can drive it
  task automatic byte_io(input logic [7:0] w, input logic rw, output logic [7:0] r,
                         output logic rr);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(rw, rr);
  endtask
endmodule

// file: fsr_i2c_readout_sva.sv
`timescale 1ns/100ps
module fsr_i2c_readout_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire fsr_pkg::fsr_flow_t flow_raw_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic busy_out,
  input wire fsr_pkg::fsr_flow_t flow_out
);
  import fsr_pkg::*;
  logic [3:0] bit_cnt_r;
  logic [7:0] addr_r;
  logic in_addr_r;
  logic [11:0] stab_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_r <= 4'h0;
      addr_r <= 8'h00;
      in_addr_r <= 1'b0;
    end else if (scl_in && $fell(sda_in)) begin
      bit_cnt_r <= 4'h0;
      in_addr_r <= 1'b1;
    end else if ($rose(scl_in) && in_addr_r) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r < 4'h8) addr_r <= {addr_r[6:0], sda_in};
      else in_addr_r <= 1'b0;
    end
  end
  // Saturates so a long quiet spell never wraps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) stab_r <= 12'h000;
    else if ($changed(flow_raw_in)) stab_r <= 12'h000;
    else if (stab_r != 12'hFFF) stab_r <= stab_r + 12'h001;
  end
  chk_sda_drive_low: assert property (sda_out == 1'b0)
    else $error("sda data not low");
  chk_idle_release: assert property (!busy_out |-> sda_oe_n_out)
    else $error("driving while idle");
  chk_start_busy: assert property (scl_in && $fell(sda_in) |-> ##[1:8] busy_out)
    else $error("start missed");
  chk_stop_idle: assert property (scl_in && $rose(sda_in) |-> ##[1:10] !busy_out)
    else $error("stop missed");
  chk_oe_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("sda moved while scl high");
  chk_addr_ack: assert property ($rose(scl_in) && in_addr_r && bit_cnt_r == 4'h8 |->
    sda_oe_n_out == (addr_r != 8'hA1)) else $error("address response wrong");
  chk_flow_range: assert property (flow_out >= 12'h199 && flow_out <= 12'hE66)
    else $error("flow out of range");
  chk_flow_follow: assert property (stab_r == 12'h7D0 && flow_raw_in >= 12'h199 &&
    flow_raw_in <= 12'hE66 |-> flow_out == flow_raw_in) else $error("flow stale");
  cover property ($rose(scl_in) && in_addr_r && bit_cnt_r == 4'h8 && !sda_oe_n_out);
  cover property ($fell(busy_out));
  cover property (flow_out == 12'hE66);
endmodule
bind fsr_i2c_readout fsr_i2c_readout_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .scl_in(scl_in), .sda_in(sda_in), .flow_raw_in(flow_raw_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .busy_out(busy_out), .flow_out(flow_out));

// file: tb_fsr_i2c_readout.sv
`timescale 1ns/100ps
module tb_fsr_i2c_readout;
  import fsr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl, ctl_sda, sda_out, sda_oe_n_out, busy_out;
  fsr_flow_t flow_raw_in = 12'h199;
  fsr_flow_t flow_out;
  int n_errors = 0;
  int cmp_count = 0;
  // Pull-up wire: low if either side pulls
  wire sda_w = ctl_sda & (sda_oe_n_out | sda_out);
  fsr_i2c_readout u_dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
    .flow_raw_in(flow_raw_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .busy_out(busy_out), .flow_out(flow_out));
  fsr_i2c_ctl u_ctl (.scl_out(scl), .sda_out(ctl_sda), .sda_in(sda_w));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic read_one(input fsr_flow_t raw, input fsr_flow_t exp);
    logic [7:0] b[5];
    logic [7:0] sum;
    logic r;
    @(posedge clk_in);
    #1 flow_raw_in = raw;
    repeat (2100) @(posedge clk_in);
    #1;
    chk(flow_out === exp, "sample");
    u_ctl.start_c();
    u_ctl.byte_io(8'hA1, 1'b1, b[0], r);
    chk(r === 1'b0, "addr ack");
    // New front-end value mid-read must not leak into this frame
    flow_raw_in = ~raw;
    sum = 8'h00;
    for (int i = 0; i < 5; i++) begin
      u_ctl.byte_io(8'hFF, i == 4, b[i], r);
      sum += b[i];
    end
    u_ctl.stop_c();
    chk(b[1] === {4'h0, exp[11:8]} && b[3] === b[1], "high");
    chk(b[2] === exp[7:0] && b[4] === b[2], "low");
    chk(sum === 8'h00, "sum");
    repeat (10) @(posedge clk_in);
    #1;
    chk(busy_out === 1'b0 && sda_oe_n_out === 1'b1, "idle");
  endtask
  task automatic bad_addr(input logic [7:0] a);
    logic [7:0] d;
    logic r;
    // Keep every pin change one step past the sampling edge
    @(posedge clk_in);
    #1;
    u_ctl.start_c();
    u_ctl.byte_io(a, 1'b1, d, r);
    chk(r === 1'b1, "bad addr");
    u_ctl.byte_io(8'hFF, 1'b1, d, r);
    chk(d === 8'hFF, "bus held");
    u_ctl.stop_c();
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk(sda_oe_n_out === 1'b1 && busy_out === 1'b0 && flow_out === 12'h199, "reset");
    read_one(12'h199, 12'h199);
    read_one(12'h000, 12'h199);
    read_one(12'hFFF, 12'hE66);
    read_one(12'h5A3, 12'h5A3);
    bad_addr(8'hA0);
    bad_addr(8'hA3);
    end_sim();
  end
  // Whole run needs about 127 us
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
endmodule
